// ---- dds_ctrl_map.svh ----
// Synthesizer control constants: offsets, fields, resets, widths.
// Definitions only; included by the design and the bench.
// Function
// RULE1 - Output rate is the chosen word's fraction of the clock.
// RULE2 - Accumulator adds frequency word A or B per choice.
// RULE3 - Frequency choice by select pin or control bit.
// RULE4 - Host holds frequency pin steady under bit control.
// RULE5 - Phase word A or B added per phase choice.
// RULE6 - Phase choice by select pin or control bit.
// RULE7 - Host holds phase pin steady under bit control.
// RULE8 - Reset pin zeroes accumulator and lookup phase.
// RULE9 - Reset pin never alters addressable words.
// RULE10 - Sleep pin high powers the DAC down.
// RULE11 - Sleep pin or powerdown bit powers the DAC down.
// RULE12 - A serial transfer carries one 16-bit word.
// RULE13 - One data bit per serial clock falling edge.
// RULE14 - Sync falling starts a new word.
// RULE15 - Sign pin driven only when its enable bit is 1.
// RULE16 - Source bit picks comparator or accumulator MSB.
// RULE17 - 28-bit accumulator adds chosen word each clock, wraps.
// RULE18 - Chosen 12-bit phase word added to accumulator top.
// RULE19 - Lookup phase is the upper 12 bits of the sum.
// RULE20 - Select pins sampled on the clock rising edge.
// RULE21 - Commit after 16 falls under low sync; drop partial words.
// RULE22 - Config bit picks pin or bit control; bits ignore pins.
`ifndef DDS_CTRL_MAP_SVH
`define DDS_CTRL_MAP_SVH

`define DDS_FREQ_W 28
`define DDS_PHASE_W 12
`define DDS_SER_W 16
`define DDS_SER_CNT_W 5
`define DDS_AXI_ADDR_W 8

`define DDS_OFS_CTRL 8'h00
`define DDS_OFS_FREQ_A 8'h04
`define DDS_OFS_FREQ_B 8'h08
`define DDS_OFS_PHASE_A 8'h0C
`define DDS_OFS_PHASE_B 8'h10
`define DDS_OFS_STATUS 8'h14
`define DDS_OFS_SERIAL 8'h18

`define DDS_CTRL_FREQ_BIT 0
`define DDS_CTRL_PHASE_BIT 1
`define DDS_CTRL_BY_BIT 2
`define DDS_CTRL_PDOWN 3
`define DDS_CTRL_SIGN_EN 4
`define DDS_CTRL_SIGN_SRC 5
`define DDS_CTRL_W 6
`define DDS_CTRL_RESET 6'h00

`define DDS_FREQ_RESET 28'h0000000
`define DDS_PHASE_RESET 12'h000

`define DDS_RESP_OKAY 2'h0
`define DDS_RESP_SLVERR 2'h2

`endif

// ---- dds_pkg.sv ----
// Types shared by the synthesizer control block.
// Assumes nothing beyond a SystemVerilog compiler.
package dds_pkg;

    // Progress of one serial word on the three-wire link.
    typedef enum logic [1:0] {
        DDS_RX_IDLE,
        DDS_RX_SHIFT,
        DDS_RX_DONE
    } dds_rx_state_t;

    // Register slots as decoded from a bus address.
    typedef enum logic [2:0] {
        DDS_REG_CTRL,
        DDS_REG_FREQ_A,
        DDS_REG_FREQ_B,
        DDS_REG_PHASE_A,
        DDS_REG_PHASE_B,
        DDS_REG_STATUS,
        DDS_REG_SERIAL,
        DDS_REG_NONE
    } dds_reg_t;

endpackage

// ---- dds_sync.sv ----
// Two-stage synchroniser for asynchronous pins.
// Assumes independent bits; no word coherence.
`timescale 1ns/1ps
`default_nettype none
module dds_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // Only the second stage reads the first, so metastability settles.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            stage_one <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end

endmodule
`default_nettype wire

// ---- dds_serial_rx.sv ----
// Serial word receiver: shifts synchronised data on falling serial clock edges.
// Assumes its inputs have already passed the pin synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "dds_ctrl_map.svh"
module dds_serial_rx (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic frame_sync_n_in,
    input wire logic serial_in,
    output logic [`DDS_SER_W-1:0] word_out,
    output logic word_valid_out
);

    dds_pkg::dds_rx_state_t state;
    logic sclk_prev;
    logic [`DDS_SER_CNT_W-1:0] bit_count;
    logic [`DDS_SER_W-1:0] shift;
    wire logic sclk_fall = sclk_prev & ~sclk_in;
    wire logic last_bit = (bit_count == 5'(`DDS_SER_W - 1));

    // Sync high ends the frame; a short word is dropped.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state <= dds_pkg::DDS_RX_IDLE;
            sclk_prev <= 1'b1;
            bit_count <= '0;
            shift <= '0;
            word_out <= '0;
            word_valid_out <= 1'b0;
        end else begin
            sclk_prev <= sclk_in;
            word_valid_out <= 1'b0;
            if (frame_sync_n_in) begin
                state <= dds_pkg::DDS_RX_IDLE; // see RULE21
                bit_count <= '0;
            end else begin
                case (state)
                    dds_pkg::DDS_RX_IDLE: begin
                        state <= dds_pkg::DDS_RX_SHIFT; // see RULE14
                        bit_count <= '0;
                    end
                    dds_pkg::DDS_RX_SHIFT: begin
                        if (sclk_fall) begin
                            shift <= {shift[`DDS_SER_W-2:0], serial_in}; // see RULE13
                            bit_count <= bit_count + 5'h01;
                            if (last_bit) begin
                                word_out <= {shift[`DDS_SER_W-2:0], serial_in}; // see RULE12
                                word_valid_out <= 1'b1; // see RULE21
                                state <= dds_pkg::DDS_RX_DONE;
                            end
                        end
                    end
                    dds_pkg::DDS_RX_DONE: begin
                        state <= dds_pkg::DDS_RX_DONE; // Extra edges wait for a new frame.
                    end
                    default: begin
                        state <= dds_pkg::DDS_RX_IDLE;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ---- dds_ctrl_top.sv ----
// Synthesizer control: AXI4-Lite registers, accumulator, pins.
// Adds the phase offset; drives powerdown and sign pins.
// Assumes the system clock is the master clock.
// All pins are asynchronous and synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "dds_ctrl_map.svh"
module dds_ctrl_top #(
    parameter int FREQ_W = `DDS_FREQ_W,
    parameter int PHASE_W = `DDS_PHASE_W
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [`DDS_AXI_ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic [2:0] s_axi_awprot_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [`DDS_AXI_ADDR_W-1:0] s_axi_araddr_in,
    input wire logic [2:0] s_axi_arprot_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic freq_choose_pin_in,
    input wire logic phase_choose_pin_in,
    input wire logic dds_reset_in,
    input wire logic sleep_in,
    input wire logic serial_clk_in,
    input wire logic serial_in_in,
    input wire logic frame_sync_n_in,
    input wire logic comparator_in,
    output logic [PHASE_W-1:0] phase_addr_out,
    output logic dac_powerdown_out,
    output logic sign_bit_out,
    output logic sign_bit_oe_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    // Maps a byte address to a register slot; both bus directions use it.
    function automatic dds_pkg::dds_reg_t reg_of(input logic [`DDS_AXI_ADDR_W-1:0] addr);
        case (addr)
            `DDS_OFS_CTRL: reg_of = dds_pkg::DDS_REG_CTRL;
            `DDS_OFS_FREQ_A: reg_of = dds_pkg::DDS_REG_FREQ_A;
            `DDS_OFS_FREQ_B: reg_of = dds_pkg::DDS_REG_FREQ_B;
            `DDS_OFS_PHASE_A: reg_of = dds_pkg::DDS_REG_PHASE_A;
            `DDS_OFS_PHASE_B: reg_of = dds_pkg::DDS_REG_PHASE_B;
            `DDS_OFS_STATUS: reg_of = dds_pkg::DDS_REG_STATUS;
            `DDS_OFS_SERIAL: reg_of = dds_pkg::DDS_REG_SERIAL;
            default: reg_of = dds_pkg::DDS_REG_NONE;
        endcase
    endfunction

    // Merges write data into a word under the byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old_word,
                                          input logic [31:0] new_word,
                                          input logic [3:0] strb);
        logic [31:0] result;
        result = old_word;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                result[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        merge = result;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    localparam int PIN_W = 8;
    localparam logic [PIN_W-1:0] PIN_RESET = 8'h30;

    logic [PIN_W-1:0] pins_sync;

    // Frame sync and serial clock idle high, so they leave reset high.
    dds_sync #(
        .WIDTH(PIN_W),
        .RESET_VAL(PIN_RESET)
    ) u_pin_sync (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .async_in({comparator_in, serial_in_in, frame_sync_n_in, serial_clk_in,
                   sleep_in, dds_reset_in, phase_choose_pin_in, freq_choose_pin_in}),
        .sync_out(pins_sync)
    );

    wire logic freq_pin = pins_sync[0]; // see RULE20
    wire logic phase_pin = pins_sync[1]; // see RULE20
    wire logic reset_pin = pins_sync[2];
    wire logic sleep_pin = pins_sync[3];
    wire logic sclk_sync = pins_sync[4];
    wire logic frame_sync_n_n_sync = pins_sync[5];
    wire logic serial_in_sync = pins_sync[6];
    wire logic comparator_sync = pins_sync[7];

    ////////////////////////////////////////////////////////////////////////////
    // Serial word receiver.

    logic [`DDS_SER_W-1:0] rx_word;
    logic rx_valid;

    dds_serial_rx u_serial_rx (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .sclk_in(sclk_sync),
        .frame_sync_n_in(frame_sync_n_n_sync),
        .serial_in(serial_in_sync),
        .word_out(rx_word),
        .word_valid_out(rx_valid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Addressable words; the reset pin never touches these.

    logic [`DDS_CTRL_W-1:0] ctrl;
    logic [FREQ_W-1:0] freq_word_a;
    logic [FREQ_W-1:0] freq_word_b;
    logic [PHASE_W-1:0] phase_word_a;
    logic [PHASE_W-1:0] phase_word_b;
    logic [`DDS_SER_W-1:0] serial_word;
    logic [7:0] serial_count;

    wire logic freq_choose_bit = ctrl[`DDS_CTRL_FREQ_BIT];
    wire logic phase_choose_bit = ctrl[`DDS_CTRL_PHASE_BIT];
    wire logic select_by_bit = ctrl[`DDS_CTRL_BY_BIT];
    wire logic dac_powerdown_bit = ctrl[`DDS_CTRL_PDOWN];
    wire logic sign_out_enable = ctrl[`DDS_CTRL_SIGN_EN];
    wire logic sign_source_select = ctrl[`DDS_CTRL_SIGN_SRC];

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel, one write at a time.
    // Address and data in either order; response once both held.

    logic aw_held;
    logic w_held;
    logic [`DDS_AXI_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    wire logic aw_take = s_axi_awvalid_in & s_axi_awready_out;
    wire logic w_take = s_axi_wvalid_in & s_axi_wready_out;
    wire logic do_write = aw_held & w_held & ~s_axi_bvalid_out;
    wire dds_pkg::dds_reg_t wr_reg = reg_of(aw_addr);
    wire logic next_awready = s_axi_awvalid_in & ~s_axi_awready_out & ~aw_held
                              & ~s_axi_bvalid_out;
    wire logic next_wready = s_axi_wvalid_in & ~s_axi_wready_out & ~w_held
                             & ~s_axi_bvalid_out;

    // Ready is a one-cycle pulse so each channel takes exactly one item.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            s_axi_awready_out <= next_awready;
            s_axi_wready_out <= next_wready;
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // Response holds until the master takes it; read-only slots answer OKAY.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `DDS_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (wr_reg == dds_pkg::DDS_REG_NONE) ? `DDS_RESP_SLVERR
                                                                 : `DDS_RESP_OKAY;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // Register writes. The reset pin is deliberately absent here.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ctrl <= `DDS_CTRL_RESET;
            freq_word_a <= `DDS_FREQ_RESET;
            freq_word_b <= `DDS_FREQ_RESET;
            phase_word_a <= `DDS_PHASE_RESET;
            phase_word_b <= `DDS_PHASE_RESET;
        end else if (do_write) begin // see RULE9
            case (wr_reg)
                dds_pkg::DDS_REG_CTRL:
                    ctrl <= `DDS_CTRL_W'(merge(32'(ctrl), w_data, w_strb));
                dds_pkg::DDS_REG_FREQ_A:
                    freq_word_a <= FREQ_W'(merge(32'(freq_word_a), w_data, w_strb));
                dds_pkg::DDS_REG_FREQ_B:
                    freq_word_b <= FREQ_W'(merge(32'(freq_word_b), w_data, w_strb));
                dds_pkg::DDS_REG_PHASE_A:
                    phase_word_a <= PHASE_W'(merge(32'(phase_word_a), w_data, w_strb));
                dds_pkg::DDS_REG_PHASE_B:
                    phase_word_b <= PHASE_W'(merge(32'(phase_word_b), w_data, w_strb));
                default: begin
                end
            endcase
        end
    end

    // Last complete serial word and a count of them.
    // Software decodes the command.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            serial_word <= '0;
            serial_count <= 8'h00;
        end else if (rx_valid) begin
            serial_word <= rx_word; // see RULE12
            serial_count <= serial_count + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Synthesis path.

    logic [FREQ_W-1:0] accum;

    // Bit control ignores the pins, so a pin left floating cannot steer it.
    wire logic freq_sel = select_by_bit ? freq_choose_bit : freq_pin; // see RULE3 RULE22
    wire logic phase_sel = select_by_bit ? phase_choose_bit : phase_pin; // see RULE6 RULE22
    wire logic [FREQ_W-1:0] freq_word = freq_sel ? freq_word_b : freq_word_a; // see RULE2
    wire logic [PHASE_W-1:0] phase_word = phase_sel ? phase_word_b : phase_word_a; // see RULE5
    wire logic [PHASE_W-1:0] phase_sum =
        accum[FREQ_W-1 -: PHASE_W] + phase_word; // see RULE18 RULE19
    wire logic powerdown = sleep_pin | dac_powerdown_bit; // see RULE10 RULE11
    wire logic sign_value = sign_source_select ? comparator_sync
                                               : accum[FREQ_W-1]; // see RULE16

    // Output rate is freq_word / 2^28 of the clock; the sum wraps naturally.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || reset_pin) begin
            accum <= '0; // see RULE8
        end else begin
            accum <= accum + freq_word; // see RULE1 RULE17
        end
    end

    // The lookup address is zero under reset, which gives the midscale output.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || reset_pin) begin
            phase_addr_out <= '0; // see RULE8
        end else begin
            phase_addr_out <= phase_sum; // see RULE19
        end
    end

    // Powerdown and the sign pin; the pin is released when not enabled.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            dac_powerdown_out <= 1'b0;
            sign_bit_out <= 1'b0;
            sign_bit_oe_out <= 1'b0;
        end else begin
            dac_powerdown_out <= powerdown; // see RULE10
            sign_bit_out <= sign_out_enable & sign_value;
            sign_bit_oe_out <= sign_out_enable; // see RULE15
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel. One read at a time; the answer is registered.

    wire dds_pkg::dds_reg_t rd_reg = reg_of(s_axi_araddr_in);
    wire logic ar_take = s_axi_arvalid_in & s_axi_arready_out;
    wire logic next_arready = s_axi_arvalid_in & ~s_axi_arready_out & ~s_axi_rvalid_out;
    wire logic [31:0] status_word = {16'h0000, serial_count, 3'h0, accum[FREQ_W-1],
                                     powerdown, reset_pin, phase_sel, freq_sel};
    logic [31:0] rd_value;

    // Read selection; unmapped slots return zero with an error response.
    always_comb begin
        case (rd_reg)
            dds_pkg::DDS_REG_CTRL: rd_value = 32'(ctrl);
            dds_pkg::DDS_REG_FREQ_A: rd_value = 32'(freq_word_a);
            dds_pkg::DDS_REG_FREQ_B: rd_value = 32'(freq_word_b);
            dds_pkg::DDS_REG_PHASE_A: rd_value = 32'(phase_word_a);
            dds_pkg::DDS_REG_PHASE_B: rd_value = 32'(phase_word_b);
            dds_pkg::DDS_REG_STATUS: rd_value = status_word;
            dds_pkg::DDS_REG_SERIAL: rd_value = 32'(serial_word);
            default: rd_value = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= `DDS_RESP_OKAY;
        end else begin
            s_axi_arready_out <= next_arready;
            if (ar_take) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= rd_value;
                s_axi_rresp_out <= (rd_reg == dds_pkg::DDS_REG_NONE) ? `DDS_RESP_SLVERR
                                                                     : `DDS_RESP_OKAY;
            end else if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ---- dds_ctrl_asserts.sv ----
// Checker of the synthesizer control block.
// Sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module dds_ctrl_asserts #(
    parameter int PHASE_W = 12
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic dds_reset_in,
    input wire logic sleep_in,
    input wire logic [PHASE_W-1:0] phase_addr_out,
    input wire logic dac_powerdown_out,
    input wire logic sign_bit_out,
    input wire logic sign_bit_oe_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////////////
    // Four cycles cover two sync flops and the output flop.
    chk_sign_gated: assert property (!sign_bit_oe_out |-> !sign_bit_out)
        else $error("sign high while off");
    chk_sleep_down: assert property (sleep_in [*4] |=> dac_powerdown_out)
        else $error("sleep but DAC on");
    chk_reset_mid: assert property (dds_reset_in [*4] |=> phase_addr_out == '0)
        else $error("reset but phase not zero");
    // Bus answers stand until taken and drop right after.
    chk_b_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("bvalid dropped early");
    chk_r_stands: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out)
        else $error("rvalid dropped early");
    chk_b_ends: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
        else $error("bvalid repeated");
    chk_r_ends: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
        else $error("rvalid repeated");
    chk_ar_answer: assert property ($rose(s_axi_arready_out) |=> !s_axi_arready_out && s_axi_rvalid_out)
        else $error("read answer late");
    chk_aw_pulse: assert property ($rose(s_axi_awready_out) |=> !s_axi_awready_out)
        else $error("awready too long");
endmodule
bind dds_ctrl_top dds_ctrl_asserts #(.PHASE_W(PHASE_W)) u_chk (.*);
`default_nettype wire

// ---- dds_host_link.sv ----
// Host side of the three-wire serial link.
// Assumes data is taken on falling clock edges under low sync.
`timescale 1ns/1ps
`default_nettype none
module dds_host_link (
    output logic sclk_out,
    output logic sync_n_out,
    output logic serial_in_out
);
    // Clock and sync stand high between frames.
    initial begin
        sclk_out = 1'b1;
        sync_n_out = 1'b1;
        serial_in_out = 1'b0;
    end
    // Sends the top nbits, MSB first; under 16 aborts the frame.
    task automatic send(input logic [15:0] word, input int nbits);
        sync_n_out <= 1'b0;
        #317;
        for (int i = 15; i >= 16 - nbits; i--) begin
            serial_in_out <= word[i];
            #200;
            sclk_out <= 1'b0;
            #200;
            sclk_out <= 1'b1;
        end
        #130;
        sync_n_out <= 1'b1;
        // Released data flips so a stale bit cannot pass.
        serial_in_out <= ~serial_in_out;
        #400;
    endtask
endmodule
`default_nettype wire

// ---- dds_control_interface_bench.sv ----
// Bench of the synthesizer control block: AXI4-Lite call sequences.
// Assumes the link model and checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "dds_ctrl_map.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_errors++; \
$display("FAIL %s expected %h seen %h", nm, ex, got); end end
module dds_control_interface_bench;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
    logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic freq_choose_pin_in = 1'b0, phase_choose_pin_in = 1'b0, dds_reset_in = 1'b0;
    logic sleep_in = 1'b0, comparator_in = 1'b0, serial_clk_in, serial_in_in, frame_sync_n_in;
    logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
    logic [2:0] s_axi_awprot_in = 3'h0, s_axi_arprot_in = 3'h0;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, dac_powerdown_out, sign_bit_out, sign_bit_oe_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic [11:0] phase_addr_out;
    int n_errors = 0, samples_checked = 0;
    always #25 clk_sys_in = ~clk_sys_in;
    dds_ctrl_top DUT (.*);
    dds_host_link host (.sclk_out(serial_clk_in), .sync_n_out(frame_sync_n_in),
        .serial_in_out(serial_in_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    // Write: aw and w together, each dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = `DDS_RESP_OKAY);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_bvalid_out !== 1'b1);
        `CHK("bresp", er, s_axi_bresp_out)
        s_axi_bready_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    // Read; a trailing edge separates calls.
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er = `DDS_RESP_OKAY);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
        end while (s_axi_rvalid_out !== 1'b1);
        `CHK("rdata", ed, s_axi_rdata_out)
        `CHK("rresp", er, s_axi_rresp_out)
        s_axi_rready_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    // Lookup phase change over one clock.
    task automatic pstep(input logic [11:0] e);
        logic [11:0] p;
        cyc(6);
        p = phase_addr_out;
        cyc(1);
        `CHK("phase step", e, 12'(phase_addr_out - p))
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog, far beyond the sequence length.
    initial begin
        #2000000;
        n_errors++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [11:0] p;
        cyc(8);
        rst_n_in <= 1'b1;
        cyc(1);
        // Reset values, then an unmapped address both ways.
        for (int a = 0; a <= 8'h18; a += 4) rd(8'(a), 32'h0);
        rd(8'h1C, 32'h0, `DDS_RESP_SLVERR);
        wr(8'h1C, 32'h1, `DDS_RESP_SLVERR);
        // Bit control, frozen accumulator: raw phase words.
        wr(`DDS_OFS_PHASE_A, 32'h123);
        wr(`DDS_OFS_PHASE_B, 32'h456);
        wr(`DDS_OFS_CTRL, 32'h5);
        pstep(12'h0);
        `CHK("phase a", 12'h123, phase_addr_out)
        wr(`DDS_OFS_CTRL, 32'h7);
        pstep(12'h0);
        `CHK("phase b", 12'h456, phase_addr_out)
        wr(`DDS_OFS_FREQ_A, 32'h0010000);
        pstep(12'h0);
        // Pin control: the pin picks the frequency word.
        wr(`DDS_OFS_CTRL, 32'h0);
        pstep(12'h1);
        freq_choose_pin_in <= 1'b1;
        pstep(12'h0);
        wr(`DDS_OFS_FREQ_B, 32'hFFF0000);
        pstep(12'hFFF);
        wr(`DDS_OFS_FREQ_B, 32'h0);
        phase_choose_pin_in <= 1'b1;
        cyc(6);
        p = phase_addr_out;
        phase_choose_pin_in <= 1'b0;
        cyc(6);
        `CHK("phase pin", 12'h333, 12'(p - phase_addr_out))
        // Reset pin zeroes the output, keeps the words.
        dds_reset_in <= 1'b1;
        cyc(5);
        `CHK("reset phase", 12'h0, phase_addr_out)
        dds_reset_in <= 1'b0;
        rd(`DDS_OFS_FREQ_A, 32'h0010000);
        rd(`DDS_OFS_PHASE_B, 32'h456);
        // Sleep pin, then powerdown bit.
        sleep_in <= 1'b1;
        cyc(5);
        `CHK("sleep pin", 1'b1, dac_powerdown_out)
        sleep_in <= 1'b0;
        wr(`DDS_OFS_CTRL, 32'h8);
        cyc(4);
        `CHK("pdown bit", 1'b1, dac_powerdown_out)
        // Sign: comparator, MSB (zero), disabled.
        comparator_in <= 1'b1;
        wr(`DDS_OFS_CTRL, 32'h30);
        cyc(5);
        `CHK("pdown off", 1'b0, dac_powerdown_out)
        `CHK("sign comp", 2'b11, {sign_bit_oe_out, sign_bit_out})
        wr(`DDS_OFS_CTRL, 32'h10);
        cyc(4);
        `CHK("sign msb", 2'b10, {sign_bit_oe_out, sign_bit_out})
        wr(`DDS_OFS_CTRL, 32'h20);
        cyc(4);
        `CHK("sign off", 2'b00, {sign_bit_oe_out, sign_bit_out})
        // Serial: whole, aborted, whole; the count tracks whole words only.
        host.send(16'hA5C3, 16);
        cyc(1);
        rd(`DDS_OFS_SERIAL, 32'hA5C3);
        host.send(16'h0F0F, 7);
        cyc(1);
        rd(`DDS_OFS_SERIAL, 32'hA5C3);
        rd(`DDS_OFS_STATUS, 32'h101);
        host.send(16'h3C5A, 16);
        cyc(1);
        rd(`DDS_OFS_SERIAL, 32'h3C5A);
        rd(`DDS_OFS_STATUS, 32'h201);
        final_report();
    end
endmodule
`default_nettype wire
